// *** design/ebpc_top.sv ***
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ebpc_top (
	input  wire logic        clock,        // 100 MHz system clock
	input  wire logic        srst,         // sync reset, high
	input  wire logic [7:0]  reg_addr,     // register offset
	input  wire logic [7:0]  reg_wdata,    // register write data
	input  wire logic        reg_wr,       // write strobe
	input  wire logic        reg_rd,       // read strobe
	output logic      [7:0]  reg_rdata,    // read data, next cycle
	output logic             reg_ext,      // access is off-chip
	input  wire logic        cpu_req,      // bus cycle request
	input  wire logic [15:0] cpu_addr,     // bus address
	input  wire logic        cpu_wide,     // word access
	input  wire logic        cpu_wr,       // write cycle
	input  wire logic        cpu_ram,      // internal RAM cycle
	input  wire logic [15:0] cpu_wdata,    // write word
	input  wire logic [1:0]  queue_status, // instruction queue
	output logic             cpu_ack,      // cycle done pulse
	output logic      [15:0] cpu_rdata,    // read word
	output logic             bus_busy,     // cycle in progress
	input  wire logic [7:0]  pa_in,        // port A pads
	output logic      [7:0]  pa_out,       // port A drive
	output logic      [7:0]  pa_oe,        // port A enable
	input  wire logic [7:0]  pb_in,        // port B pads
	output logic      [7:0]  pb_out,       // port B drive
	output logic      [7:0]  pb_oe,        // port B enable
	input  wire logic [7:0]  pe_in,        // port E pads
	output logic      [7:0]  pe_out,       // port E drive
	output logic      [7:0]  pe_oe,        // port E enable
	output logic      [7:0]  pe_pull       // port E pull-ups
);
	import ebpc_pkg::*;

	// ----------------------------------------------------------
	// control registers
	// ----------------------------------------------------------
	ebpc_mode_t  mode_q;  // operating mode
	logic        eme_q;   // port E emulation bit
	logic [7:0]  asgn_q;  // port E assignment
	logic [7:0]  pull_q;  // pull-up control
	logic [4:0]  base_q;  // register block base, 2K steps
	logic        narrow_follow_space_bit_q;  // narrow follow space bit
	logic        exp;     // expanded mode
	logic        narrow;  // expanded narrow mode
	logic        vis;     // offset present on chip
	logic        hit;     // write strobe on a present offset

	assign exp    = ebpc_is_exp(mode_q);
	assign narrow = ebpc_is_narrow(mode_q);

	// which offsets stay on chip in this mode
	always_comb begin
		vis = 1'b1;
		if (mode_q == M_PER && reg_addr <= OFF_EXP_LAST)
			vis = 1'b0; // RULE6 RULE15
		if (exp && reg_addr <= OFF_PB_DIR)
			vis = 1'b0; // RULE7
		if (exp && eme_q &&
		    (reg_addr == OFF_PE_DATA || reg_addr == OFF_PE_DIR))
			vis = 1'b0; // RULE8
	end
	assign hit = reg_wr && vis;

	// mode write reloads the assignment default for that mode
	always_ff @(posedge clock) begin
		if (srst) begin
			mode_q <= M_NSC;
			eme_q  <= 1'b0;
			asgn_q <= ASGN_RST_NSC;
		end else if (hit && reg_addr == OFF_BUS_MODE) begin
			mode_q <= ebpc_mode_t'(reg_wdata[2:0]);
			eme_q  <= reg_wdata[MODE_EME];
			asgn_q <= ebpc_asgn_rst(ebpc_mode_t'(reg_wdata[2:0]));
		end else if (hit && reg_addr == OFF_PE_ASGN) begin
			asgn_q <= reg_wdata; // RULE13
		end
	end

	// remaining control registers
	always_ff @(posedge clock) begin
		if (srst) begin
			pull_q <= 8'h00;
			base_q <= BASE_RST;
			narrow_follow_space_bit_q <= 1'b0;
		end else if (hit) begin
			if (reg_addr == OFF_PULL) pull_q <= reg_wdata;
			if (reg_addr == OFF_REG_BASE) base_q <= reg_wdata[7:3];
			if (reg_addr == OFF_MISC) narrow_follow_space_bit_q <= reg_wdata[MISC_NARROW_FOLLOW_SPACE_BIT];
		end
	end

	// ----------------------------------------------------------
	// bus cycle sequencer
	// ----------------------------------------------------------
	ebpc_state_t state_q;  // bus phase
	logic [2:0]  cnt_q;    // data phase counter
	logic        take;     // request accepted
	logic        follow;   // address in follow space
	logic        nar_d;    // byte-wide cycle
	logic        wide_d;   // word cycle granted
	logic [15:0] addr_q;   // latched address
	logic [15:0] lane_q;   // lanes to drive, A high
	logic        wr_q;     // latched write
	logic        wide_q;   // latched word flag
	logic        nar_q;    // latched byte-wide bus
	logic        swap_q;   // latched swap
	logic        strb_q;   // low byte strobe level
	logic        rnw_q;    // read/write level
	logic [7:0]  a_sync;   // port A synced pads
	logic [7:0]  b_sync;   // port B synced pads

	// requests outside idle or outside expanded are dropped
	assign take   = cpu_req && state_q == S_IDLE && exp;
	assign follow = cpu_addr[15:11] == base_q &&
	                cpu_addr[10:9] == FOLLOW_SEL; // RULE18
	// narrow modes, or the follow space with the bit set in wide
	assign nar_d  = narrow || (narrow_follow_space_bit_q && follow); // RULE1 RULE16 RULE17
	// only RAM takes a word at an odd address
	assign wide_d = cpu_wide && !nar_d &&
	                (!cpu_addr[0] || cpu_ram); // RULE2

	// phase sequence: one address cycle then the data phase
	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= S_IDLE;
			cnt_q   <= 3'h0;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (take) state_q <= S_ADDR;
				end
				S_ADDR: begin
					state_q <= S_DATA;
					cnt_q   <= 3'h1;
				end
				S_DATA: begin
					// long enough for pads to reach the sync stage
					if (cnt_q == DATA_CYC) state_q <= S_IDLE;
					else cnt_q <= cnt_q + 3'h1;
				end
			endcase
		end
	end

	// latch the cycle; encode strobe from size and bit 0
	always_ff @(posedge clock) begin
		if (srst) begin
			addr_q <= 16'h0000;
			lane_q <= 16'h0000;
			wr_q   <= 1'b0;
			wide_q <= 1'b0;
			nar_q  <= 1'b0;
			swap_q <= 1'b0;
			strb_q <= 1'b1;
			rnw_q  <= 1'b1;
		end else if (take) begin
			addr_q <= cpu_addr;
			wr_q   <= cpu_wr;
			wide_q <= wide_d;
			nar_q  <= nar_d;
			swap_q <= wide_d && cpu_addr[0];
			// word: strobe equals bit 0; byte: its inverse
			strb_q <= wide_d ? cpu_addr[0] : ~cpu_addr[0]; // RULE4 RULE5
			rnw_q  <= ~cpu_wr; // RULE4 RULE5
			if (wide_d && cpu_addr[0])
				lane_q <= {cpu_wdata[7:0], cpu_wdata[15:8]}; // RULE3
			else if (wide_d)
				lane_q <= cpu_wdata;
			else if (nar_d || !cpu_addr[0])
				lane_q <= {cpu_wdata[7:0], 8'h00}; // RULE9
			else
				lane_q <= {8'h00, cpu_wdata[7:0]}; // RULE10
		end
	end

	// answer at the last data cycle, lanes back in cpu order
	always_ff @(posedge clock) begin
		if (srst) begin
			cpu_ack   <= 1'b0;
			cpu_rdata <= 16'h0000;
			bus_busy  <= 1'b0;
		end else begin
			cpu_ack  <= state_q == S_DATA && cnt_q == DATA_CYC;
			bus_busy <= take || (state_q != S_IDLE &&
			            !(state_q == S_DATA && cnt_q == DATA_CYC));
			if (state_q == S_DATA && cnt_q == DATA_CYC) begin
				if (wide_q && swap_q)
					cpu_rdata <= {b_sync, a_sync}; // RULE3
				else if (wide_q)
					cpu_rdata <= {a_sync, b_sync};
				else if (nar_q || !addr_q[0])
					cpu_rdata <= {8'h00, a_sync};
				else
					cpu_rdata <= {8'h00, b_sync};
			end
		end
	end

	// ----------------------------------------------------------
	// pin multiplexing
	// ----------------------------------------------------------
	logic       in_data; // data phase
	logic       e_phase_clock;    // e phase clock level
	logic       dbe_n;   // data bus enable, low active
	logic [7:0] a_alt;   // port A bus level
	logic [7:0] b_alt;   // port B bus level
	logic       a_oe;    // port A bus drive
	logic       b_oe;    // port B bus drive
	logic [7:0] e_en;    // port E alternates in use
	logic [7:0] e_alt;   // port E alternate levels

	assign in_data = state_q == S_DATA;
	assign e_phase_clock    = in_data;
	assign dbe_n   = ~in_data;

	// address outside data phase, data inside it
	always_comb begin
		a_alt = in_data ? lane_q[15:8] : addr_q[15:8]; // RULE9
		a_oe  = !in_data || wr_q;
		// narrow bus keeps the low address on port B
		b_alt = (in_data && !nar_q) ? lane_q[7:0] : addr_q[7:0]; // RULE10
		b_oe  = !in_data || wr_q || nar_q;
	end

	// port E alternate selection per pin
	always_comb begin
		e_en = PE_INPUT_ONLY; // RULE12
		e_en[7] = exp && !asgn_q[PEA_NO_DBE];
		e_en[6] = exp && asgn_q[PEA_PIPE];
		e_en[5] = exp && asgn_q[PEA_PIPE];
		e_en[4] = mode_q != M_PER && !asgn_q[PEA_NO_E_PHASE_CLOCK];
		e_en[3] = exp && mode_q != M_NXN && asgn_q[PEA_STRB];
		e_en[2] = exp && asgn_q[PEA_RDW];
		e_alt = 8'h00;
		e_alt[7]   = asgn_q[PEA_INV_E] ? ~e_phase_clock : dbe_n; // RULE12
		e_alt[6:5] = queue_status;
		e_alt[4]   = e_phase_clock;
		e_alt[3]   = strb_q; // RULE1
		e_alt[2]   = rnw_q;
	end

	// ----------------------------------------------------------
	// ports
	// ----------------------------------------------------------
	logic [7:0] a_rd, b_rd, e_rd;    // data register views
	logic [7:0] a_dir, b_dir, e_dir; // direction registers
	logic [7:0] e_sync;              // port E synced pads

	ebpc_port #(.W(8), .PULL_MASK(8'h00)) u_port_a (
		.clock    (clock),
		.srst     (srst),
		.wr_data  (hit && reg_addr == OFF_PA_DATA),
		.wr_dir   (hit && reg_addr == OFF_PA_DIR),
		.wdata    (reg_wdata),
		.alt_en   ({8{exp}}), // RULE7 RULE11
		.alt_out  (a_alt),
		.alt_oe   ({8{a_oe}}),
		.pull_en  (1'b0),
		.pin_in   (pa_in),
		.pin_out  (pa_out),
		.pin_oe   (pa_oe),
		.pin_pull (),
		.pin_sync (a_sync),
		.rd_data  (a_rd),
		.dir      (a_dir)
	);

	ebpc_port #(.W(8), .PULL_MASK(8'h00)) u_port_b (
		.clock    (clock),
		.srst     (srst),
		.wr_data  (hit && reg_addr == OFF_PB_DATA),
		.wr_dir   (hit && reg_addr == OFF_PB_DIR),
		.wdata    (reg_wdata),
		.alt_en   ({8{exp}}), // RULE7 RULE11
		.alt_out  (b_alt),
		.alt_oe   ({8{b_oe}}),
		.pull_en  (1'b0),
		.pin_in   (pb_in),
		.pin_out  (pb_out),
		.pin_oe   (pb_oe),
		.pin_pull (),
		.pin_sync (b_sync),
		.rd_data  (b_rd),
		.dir      (b_dir)
	);

	// interrupt pins are alternates that never drive
	ebpc_port #(.W(8), .PULL_MASK(PE_PULL_MASK)) u_port_e (
		.clock    (clock),
		.srst     (srst),
		.wr_data  (hit && reg_addr == OFF_PE_DATA),
		.wr_dir   (hit && reg_addr == OFF_PE_DIR),
		.wdata    (reg_wdata),
		.alt_en   (e_en), // RULE13
		.alt_out  (e_alt),
		.alt_oe   (~PE_INPUT_ONLY),
		.pull_en  (pull_q[PULL_E_BIT]), // RULE14
		.pin_in   (pe_in),
		.pin_out  (pe_out),
		.pin_oe   (pe_oe),
		.pin_pull (pe_pull),
		.pin_sync (e_sync),
		.rd_data  (e_rd),
		.dir      (e_dir)
	);

	// ----------------------------------------------------------
	// register read and off-chip flag
	// ----------------------------------------------------------
	// hidden offsets read zero; the outside unit answers them
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata <= 8'h00;
			reg_ext   <= 1'b0;
		end else begin
			reg_ext   <= (reg_rd || reg_wr) && !vis; // RULE7 RULE8 RULE19
			reg_rdata <= 8'h00;
			if (reg_rd && vis) begin
				case (reg_addr)
					OFF_PA_DATA:  reg_rdata <= a_rd;
					OFF_PB_DATA:  reg_rdata <= b_rd;
					OFF_PA_DIR:   reg_rdata <= a_dir;
					OFF_PB_DIR:   reg_rdata <= b_dir;
					OFF_PE_DATA:  reg_rdata <= e_rd;
					OFF_PE_DIR:   reg_rdata <= e_dir;
					OFF_PE_ASGN:  reg_rdata <= asgn_q;
					OFF_PULL:     reg_rdata <= pull_q;
					OFF_REG_BASE: reg_rdata <= {base_q, 3'h0};
					OFF_MISC:     reg_rdata <= {1'b0, narrow_follow_space_bit_q, 6'h00};
					OFF_BUS_MODE: reg_rdata <= {4'h0, eme_q, mode_q};
					default:      reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	a_odd_word_ram: assert property ( // RULE2
		take && wide_d && cpu_addr[0] |=> strb_q && $past(cpu_ram))
		else $error("odd word strobe without RAM");
	a_byte_code: assert property ( // RULE4
		take && !wide_d |=> strb_q == !addr_q[0] && rnw_q == !wr_q)
		else $error("byte access code wrong");
	a_word_code: assert property ( // RULE5
		take && cpu_wide && !nar_d && !cpu_addr[0] |=> !strb_q)
		else $error("even word strobe not low");
	a_swap_lanes: assert property ( // RULE3
		take && wide_d && cpu_addr[0] |=>
		lane_q[7:0] == $past(cpu_wdata[15:8]) ##1 in_data)
		else $error("misaligned word lanes wrong");
	a_periph_hide: assert property ( // RULE6
		reg_rd && mode_q == M_PER && reg_addr <= OFF_EXP_LAST |=>
		reg_ext && reg_rdata == 8'h00)
		else $error("peripheral register not hidden");
	a_exp_ab_out: assert property ( // RULE7
		reg_rd && exp && reg_addr <= OFF_PB_DIR |=> reg_ext)
		else $error("port A/B register stayed on chip");
	a_eme_e_out: assert property ( // RULE8
		reg_wr && exp && eme_q && reg_addr == OFF_PE_DIR |=>
		reg_ext && $stable(e_dir))
		else $error("port E register stayed on chip");
	a_follow_byte: assert property ( // RULE17
		take && !narrow && narrow_follow_space_bit_q && follow |=> nar_q && !wide_q)
		else $error("follow space not byte wide");
	a_gpio_input: assert property ( // RULE11
		!exp && !a_dir[0] ##1 !exp |-> !pa_oe[0])
		else $error("input pin driving");
	a_irq_no_drive: assert property ( // RULE12
		pe_oe[1:0] == 2'b00)
		else $error("interrupt pin driving");
	a_pull_inputs: assert property ( // RULE14
		(pe_pull & pe_oe) == 8'h00 && (pe_pull & ~PE_PULL_MASK) == 8'h00)
		else $error("pull-up on output pin");
	a_cycle_len: assert property ( // RULE1
		take |=> state_q == S_ADDR ##1 in_data [*4] ##1 cpu_ack)
		else $error("bus cycle length wrong");

	c_word_read: cover property (take && wide_d && !cpu_wr ##6 cpu_ack);
	c_misaligned: cover property (take && wide_d && cpu_addr[0]);
	c_follow_nar: cover property (take && follow && narrow_follow_space_bit_q && !narrow);
	c_hidden_rd: cover property (reg_rd && !vis);
endmodule
`default_nettype wire

// *** design/ebpc_pkg.sv ***
// Function
// [RULE1] bus is 8 or 16 bits, strobe marks size
// [RULE2] strobe high with odd address only for RAM
// [RULE3] misaligned word: addressed byte on low half
// [RULE4] byte access codes on strobe, bit 0, rnw
// [RULE5] word access codes on strobe, bit 0, rnw
// [RULE6] peripheral mode hides first sixteen registers
// [RULE7] expanded modes move port A/B registers outside
// [RULE8] emulation bit moves port E registers outside
// [RULE9] port A carries high address and data
// [RULE10] port B carries low address, data if wide
// [RULE11] unused port pins are plain I/O by direction
// [RULE12] port E pins carry bus control alternates
// [RULE13] assignment selects function, direction only for I/O
// [RULE14] one bit pulls up port E input pins
// [RULE15] peripheral mode hides port E data
// [RULE16] wide modes mix byte and word peripherals
// [RULE17] narrow bit makes follow space byte wide
// [RULE18] follow space sits after the register block
// [RULE19] outside unit rebuilds removed port registers
package ebpc_pkg;
	// ----------------------------------------------------------
	// register offsets on the register port
	// ----------------------------------------------------------
	localparam logic [7:0] OFF_PA_DATA  = 8'h00; // port A data
	localparam logic [7:0] OFF_PB_DATA  = 8'h01; // port B data
	localparam logic [7:0] OFF_PA_DIR   = 8'h02; // port A direction
	localparam logic [7:0] OFF_PB_DIR   = 8'h03; // port B direction
	localparam logic [7:0] OFF_PE_DATA  = 8'h08; // port E data
	localparam logic [7:0] OFF_PE_DIR   = 8'h09; // port E direction
	localparam logic [7:0] OFF_PE_ASGN  = 8'h0a; // port E assignment
	localparam logic [7:0] OFF_PULL     = 8'h0c; // pull-up control
	localparam logic [7:0] OFF_REG_BASE = 8'h11; // register block base
	localparam logic [7:0] OFF_MISC     = 8'h13; // misc control
	localparam logic [7:0] OFF_BUS_MODE = 8'h14; // mode and emulation
	localparam logic [7:0] OFF_EXP_LAST = 8'h0f; // last expansion register
	// ----------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------
	localparam int PEA_NO_DBE  = 7; // pin 7 not data enable
	localparam int PEA_PIPE    = 5; // pins 6,5 queue status
	localparam int PEA_NO_E_PHASE_CLOCK = 4; // pin 4 not e clock
	localparam int PEA_STRB    = 3; // pin 3 low byte strobe
	localparam int PEA_RDW     = 2; // pin 2 read/write
	localparam int PEA_INV_E   = 0; // pin 7 inverted e clock
	localparam int PULL_E_BIT  = 4; // port E pull enable
	localparam int MISC_NARROW_FOLLOW_SPACE_BIT   = 6; // narrow follow space bit
	localparam int MODE_EME    = 3; // port E emulation bit
	localparam logic [7:0] PE_PULL_MASK  = 8'h8f; // pins with pull-ups
	localparam logic [7:0] PE_INPUT_ONLY = 8'h03; // interrupt inputs
	localparam logic [7:0] ASGN_RST_NX   = 8'h00; // normal expanded
	localparam logic [7:0] ASGN_RST_SP   = 8'h2c; // special modes
	localparam logic [7:0] ASGN_RST_PER  = 8'hd0; // peripheral
	localparam logic [7:0] ASGN_RST_NSC  = 8'h90; // normal single chip
	localparam logic [4:0] BASE_RST      = 5'h00; // block at 0x0000
	localparam logic [1:0] FOLLOW_SEL    = 2'h1;  // 0x0200..0x03ff in block
	localparam logic [2:0] DATA_CYC      = 3'h4;  // data phase length
	// ----------------------------------------------------------
	// modes and bus states
	// ----------------------------------------------------------
	typedef enum logic [2:0] {
		M_NSC = 3'h0, M_NXN = 3'h1, M_PER = 3'h2, M_NXW = 3'h3,
		M_SSC = 3'h4, M_SXN = 3'h5, M_SXW = 3'h6, M_RSV = 3'h7
	} ebpc_mode_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b001, S_ADDR = 3'b010, S_DATA = 3'b100
	} ebpc_state_t;
	// expanded: any mode that runs the external bus
	function automatic logic ebpc_is_exp(input ebpc_mode_t m);
		return m == M_NXN || m == M_NXW || m == M_SXN || m == M_SXW;
	endfunction
	function automatic logic ebpc_is_narrow(input ebpc_mode_t m);
		return m == M_NXN || m == M_SXN;
	endfunction
	// assignment reset value depends on the mode entered
	function automatic logic [7:0] ebpc_asgn_rst(input ebpc_mode_t m);
		case (m)
			M_NXN, M_NXW: return ASGN_RST_NX;
			M_PER:        return ASGN_RST_PER;
			M_NSC:        return ASGN_RST_NSC;
			default:      return ASGN_RST_SP;
		endcase
	endfunction
endpackage

// *** design/ebpc_port.sv ***
`timescale 1ns/100ps
`default_nettype none
// one 8-bit port: data, direction, pin sync, alternate override
module ebpc_port #(
	parameter int         W         = 8,
	parameter logic [7:0] PULL_MASK = 8'h00
) (
	input  wire logic         clock,    // system clock
	input  wire logic         srst,     // sync reset
	input  wire logic         wr_data,  // data register write
	input  wire logic         wr_dir,   // direction register write
	input  wire logic [W-1:0] wdata,    // write value
	input  wire logic [W-1:0] alt_en,   // pin taken by alternate
	input  wire logic [W-1:0] alt_out,  // alternate level
	input  wire logic [W-1:0] alt_oe,   // alternate drive
	input  wire logic         pull_en,  // pull-up enable
	input  wire logic [W-1:0] pin_in,   // pad level
	output logic      [W-1:0] pin_out,  // pad drive level
	output logic      [W-1:0] pin_oe,   // pad drive enable
	output logic      [W-1:0] pin_pull, // pad pull-up on
	output logic      [W-1:0] pin_sync, // synced pad level
	output logic      [W-1:0] rd_data,  // data register view
	output logic      [W-1:0] dir       // direction register
);
	logic [W-1:0] meta_q; // first sync stage, read only by sync
	logic [W-1:0] data_q; // output latch
	logic [W-1:0] oe_d;   // next drive enable
	// two stages before any logic sees a pad
	always_ff @(posedge clock) begin
		meta_q   <= pin_in;
		pin_sync <= meta_q;
	end
	// data and direction; inputs after reset is the safe choice
	always_ff @(posedge clock) begin
		if (srst) begin
			data_q <= '0;
			dir    <= '0;
		end else begin
			if (wr_data) data_q <= wdata;
			if (wr_dir) dir <= wdata;
		end
	end
	// alternate overrides direction; direction 0 is high-z
	assign oe_d = (alt_en & alt_oe) | (~alt_en & dir); // RULE11 RULE13
	// pull-ups only on masked pins that are not driving
	always_ff @(posedge clock) begin
		if (srst) begin
			pin_out  <= '0;
			pin_oe   <= '0;
			pin_pull <= '0;
		end else begin
			pin_out  <= (alt_en & alt_out) | (~alt_en & data_q);
			pin_oe   <= oe_d;
			pin_pull <= pull_en ? (PULL_MASK & ~oe_d) : '0; // RULE14
		end
	end
	// outputs read back the latch, inputs read the pad
	assign rd_data = (dir & data_q) | (~dir & pin_sync);
endmodule
`default_nettype wire

// *** tb/ebpc_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------
// byte memory on the multiplexed bus
// ----------------------------------------------------------
module ebpc_mem_model (
	input  wire logic       clock,  // system clock
	input  wire logic       narrow, // data through port A only
	input  wire logic [7:0] pa_out, // port A drive
	input  wire logic [7:0] pa_oe,  // port A enable
	input  wire logic [7:0] pb_out, // port B drive
	input  wire logic [7:0] pb_oe,  // port B enable
	input  wire logic [7:0] pe_out, // port E drive
	output logic      [7:0] pa_in,  // port A wire
	output logic      [7:0] pb_in   // port B wire
);
	logic [7:0]  mem [256]; // storage, fixed pattern at start
	logic [15:0] adr_q;     // address seen while e clock low
	logic [7:0]  ea, oa;    // even and odd byte of the pair
	logic [7:0]  la_q = 8'h00, lb_q = 8'h00; // last wire levels, known from the start
	initial foreach (mem[i]) mem[i] = i[7:0] ^ 8'h5a;
	// even byte rides port A, odd byte port B
	assign ea = adr_q[0] ? adr_q[7:0] + 8'h1 : adr_q[7:0];
	assign oa = adr_q[0] ? adr_q[7:0] : adr_q[7:0] + 8'h1;
	// released lines show the inverse of the last level, never a kind value
	assign pa_in = (pa_oe & pa_out) | (~pa_oe & (pe_out[4] ? mem[narrow ? adr_q[7:0] : ea] : ~la_q));
	assign pb_in = (pb_oe & pb_out) | (~pb_oe & (pe_out[4] && !narrow ? mem[oa] : ~lb_q));
	// latch address, store write lanes while e clock high
	always @(posedge clock) begin
		la_q <= pa_in;
		lb_q <= pb_in;
		if (!pe_out[4])
			adr_q <= {pa_out, pb_out};
		else if (!pe_out[2] && (narrow || pe_out[3] != adr_q[0]))
			mem[adr_q[7:0]] <= (narrow || !adr_q[0]) ? pa_out : pb_out;
		else if (!pe_out[2]) begin
			mem[ea] <= pa_out;
			mem[oa] <= pb_out;
		end
	end
endmodule
`default_nettype wire

// *** tb/ebpc_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module ebpc_top_tb;
	import ebpc_pkg::*;
	logic        clock = 0, srst = 1, reg_wr = 0, reg_rd = 0, reg_ext, cpu_req = 0, cpu_ack, bus_busy;
	logic        cpu_wide = 0, cpu_wr = 0, cpu_ram = 0, narrow = 0, nm = 0, nd = 0;
	logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
	logic [7:0]  pe_in, pe_out, pe_oe, pe_pull, pe_drv = 0, ref_m [256];
	logic [15:0] cpu_addr = 0, cpu_wdata = 0, cpu_rdata;
	logic [1:0]  queue_status = 0;
	int          num_errors = 0, checked = 0, seed = 38129;
	always #5 clock = ~clock;
	// port E wire: device drive where enabled, bench level elsewhere
	assign pe_in = (pe_oe & pe_out) | (~pe_oe & pe_drv);
	ebpc_top i_dut (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_ext,
		.cpu_req, .cpu_addr, .cpu_wide, .cpu_wr, .cpu_ram, .cpu_wdata, .queue_status, .cpu_ack,
		.cpu_rdata, .bus_busy, .pa_in, .pa_out, .pa_oe, .pb_in, .pb_out, .pb_oe, .pe_in, .pe_out,
		.pe_oe, .pe_pull);
	ebpc_mem_model i_mem (.clock, .narrow, .pa_out, .pa_oe, .pb_out, .pb_oe, .pe_out, .pa_in, .pb_in);
	// ----------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------
	task automatic results;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a, output logic [7:0] d, output logic x);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		x = reg_ext;
	endtask
	// one external cycle; expectations from the shadow memory
	task automatic bus(input logic [15:0] a, input logic w, wr, ram);
		logic        wrd, nw;
		logic [7:0]  a1;
		logic [15:0] wd;
		wd  = 16'($random(seed));
		a1  = a[7:0] + 8'h1;
		nw  = nm | (nd & a[15:9] == 7'h01);
		wrd = w & !nw & (!a[0] | ram);
		@(posedge clock);
		narrow       <= nw;
		cpu_req      <= 1'b1;
		cpu_addr     <= a;
		cpu_wide     <= w;
		cpu_wr       <= wr;
		cpu_ram      <= ram;
		cpu_wdata    <= wd;
		queue_status <= 2'($random(seed));
		pe_drv       <= 8'($random(seed));
		@(posedge clock);
		cpu_req <= 1'b0;
		for (int n = 0; n < 20 && cpu_ack !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		if (cpu_ack !== 1'b1) begin
			num_errors++;
			results();
		end
		`CHK("rnw", !wr, pe_out[2])
		if (!nm) `CHK("strobe", wrd ? a[0] : !a[0], pe_out[3])
		if (wr && wrd) {ref_m[a[7:0]], ref_m[a1]} = wd;
		else if (wr) ref_m[a[7:0]] = wd[7:0];
		else if (wrd) `CHK("rd_word", {ref_m[a[7:0]], ref_m[a1]}, cpu_rdata)
		else `CHK("rd_byte", ref_m[a[7:0]], cpu_rdata[7:0])
	endtask
	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		logic [7:0] d, md [3], of [7];
		logic       x, e;
		md = '{8'h03, 8'h0b, 8'h02};
		of = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h0f};
		foreach (ref_m[i]) ref_m[i] = i[7:0] ^ 8'h5a;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		// single chip: plain I/O, pull-ups only on inputs
		wreg(OFF_PA_DIR, 8'h0f);
		wreg(OFF_PA_DATA, 8'ha5);
		wreg(OFF_PULL, 8'h10);
		rreg(OFF_PA_DIR, d, x);
		`CHK("dir", 8'h0f, d)
		`CHK("pa_oe", 8'h0f, pa_oe)
		`CHK("pa_out", 4'h5, pa_out[3:0])
		`CHK("pe_oe", 8'h00, pe_oe)
		`CHK("pull", PE_PULL_MASK, pe_pull)
		rreg(8'h40, d, x);
		`CHK("unmapped", 9'h000, {x, d})
		// a request outside expanded modes is dropped
		@(posedge clock);
		cpu_req <= 1'b1;
		@(posedge clock);
		cpu_req <= 1'b0;
		repeat (6) @(posedge clock);
		#1;
		`CHK("refused", 2'b00, {cpu_ack, bus_busy})
		// registers that leave the on-chip map, per mode
		foreach (md[i]) begin
			wreg(OFF_BUS_MODE, md[i]);
			wreg(OFF_PE_DIR, md[i]);
			foreach (of[j]) begin
				rreg(of[j], d, x);
				e = md[i][2:0] == M_PER || of[j] <= 8'h03 || (md[i][3] && of[j][7:1] == 7'h04);
				`CHK("ext", e, x)
				if (e) `CHK("hidden", 8'h00, d)
				else if (of[j] == OFF_PE_DIR) `CHK("pe_dir", 8'h03, d)
			end
		end
		// traffic: wide, wide with narrow follow space, then narrow
		for (int k = 0; k < 60; k++) begin
			logic [15:0] a;
			if (k % 20 == 0) begin
				nm = k >= 40;
				nd = k[4];
				wreg(OFF_BUS_MODE, nm ? 8'h01 : 8'h03);
				wreg(OFF_PE_ASGN, 8'h0c);
				wreg(OFF_MISC, nd ? 8'h40 : 8'h00);
			end
			a = 16'($random(seed));
			// flags come from the raw draw, so follow-space cycles see words and writes too
			bus(a[12] ? {7'h01, a[8:0]} : a, a[13], a[14], a[15]);
		end
		// a write to a removed register must not land on-chip
		wreg(OFF_PA_DIR, 8'hf0);
		wreg(OFF_BUS_MODE, 8'h00);
		rreg(OFF_PA_DIR, d, x);
		`CHK("dir_kept", 8'h0f, d)
		results();
	end
endmodule
`default_nettype wire
